// ---- src/sec_feat_pkg.sv ----
// constants shared by the security and feature command block
package sec_feat_pkg;
  // command opcodes
  localparam logic [7:0] OP_SEC_ND = 8'h00_EA;
  localparam logic [7:0] OP_SEC_DO = 8'h00_EB;
  localparam logic [7:0] OP_SEEK_LO = 8'h00_70;
  localparam logic [7:0] OP_SEEK_HI = 8'h00_7F;
  localparam logic [7:0] OP_SETFEAT = 8'h00_EF;
  // security subfunctions
  localparam logic [7:0] SF_STATE = 8'h00_85;
  localparam logic [7:0] SF_UNLOCK_PD = 8'h00_86;
  localparam logic [7:0] SF_UNLOCK_CMD = 8'h00_87;
  localparam logic [7:0] UNLOCK_COUNT = 8'h00_01;
  // set features subcommands
  localparam logic [7:0] SC_8BIT_ON = 8'h00_01;
  localparam logic [7:0] SC_WC_ON = 8'h00_02;
  localparam logic [7:0] SC_XFER = 8'h00_03;
  localparam logic [7:0] SC_REL_ON = 8'h00_5D;
  localparam logic [7:0] SC_SVC_ON = 8'h00_5E;
  localparam logic [7:0] SC_NOREVERT = 8'h00_66;
  localparam logic [7:0] SC_8BIT_OFF = 8'h00_81;
  localparam logic [7:0] SC_WC_OFF = 8'h00_82;
  localparam logic [7:0] SC_CURRENT = 8'h00_9A;
  localparam logic [7:0] SC_REVERT = 8'h00_CC;
  localparam logic [7:0] SC_REL_OFF = 8'h00_DD;
  localparam logic [7:0] SC_SVC_OFF = 8'h00_DE;
  // transfer type codes in the upper five bits
  localparam logic [4:0] XT_PIO_DEF = 5'h00;
  localparam logic [4:0] XT_PIO_FC = 5'h01;
  localparam logic [4:0] XT_SW_DMA = 5'h02;
  localparam logic [4:0] XT_MW_DMA = 5'h04;
  localparam logic [2:0] MODE_NO_IORDY = 3'h1;
  // state byte bit positions
  localparam int BIT_RW = 7;
  localparam int BIT_RO = 6;
  localparam int BIT_WP = 5;
  localparam int BIT_UNLOCKED = 4;
  localparam int BIT_LOCKFLAG = 3;
  localparam int BIT_NOMEDIA = 2;
  // current step in mA per count
  localparam int CURRENT_STEP_MA = 4;
  // error register abort bit
  localparam logic [7:0] ERR_ABORT = 8'h00_04;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00_00;
  // checker cycle count
  localparam logic [3:0] PW_CHECK_MAX = 4'h8;
endpackage : sec_feat_pkg

// ---- src/pw_match.sv ----
`timescale 1ns/100ps
// password set holder and match engine for the unlock command
module pw_match
  import sec_feat_pkg::*;
#(
  parameter int NUM_PW = 2,
  parameter int PW_WORDS = 256
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic load_en,
  input wire logic [$clog2(NUM_PW)-1:0] load_idx,
  input wire logic start,
  input wire logic data_valid,
  input wire logic [15:0] data_word,
  output logic match_reg,
  output logic done_reg
);
  localparam int AW = $clog2(PW_WORDS);
  logic [15:0] pw_mem [NUM_PW][PW_WORDS];
  logic [AW:0] word_reg;
  logic [NUM_PW-1:0] hit_reg;
  logic busy_reg;
  logic [NUM_PW-1:0] hit_next;

  // per-slot hit including the word now on the bus, so the final word counts too
  always_comb begin
    hit_next = hit_reg;
    for (int i = 0; i < NUM_PW; i++) begin
      if (pw_mem[i][word_reg[AW-1:0]] != data_word) hit_next[i] = 1'b0;
    end
  end

  // store words written into a slot (password set is loaded by neighbour logic)
  always_ff @(posedge CLK) begin
    if (load_en && data_valid) begin
      pw_mem[load_idx][word_reg[AW-1:0]] <= data_word;
    end
  end

  // word counter and per-slot running compare
  always_ff @(posedge CLK) begin
    if (RST) begin
      word_reg <= '0;
      hit_reg <= '0;
      busy_reg <= 1'b0;
      match_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start) begin
        word_reg <= '0;
        hit_reg <= '1;
        busy_reg <= 1'b1;
      end else if (busy_reg && data_valid) begin
        hit_reg <= hit_next;
        word_reg <= word_reg + 1'b1;
        if (word_reg == (AW+1)'(PW_WORDS - 1)) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          match_reg <= |hit_next;
        end
      end else if (load_en && data_valid) begin
        word_reg <= (word_reg == (AW+1)'(PW_WORDS - 1)) ? '0 : word_reg + 1'b1;
      end
    end
  end


  a_match_after_done: assert property (@(posedge CLK) disable iff (RST)
    done_reg |-> !busy_reg) else $error("match engine busy after done");
endmodule : pw_match

// ---- src/sec_feat_cmd.sv ----
`timescale 1ns/100ps
// security, seek and set features command interpreter
// ************************************************************
// Overview of operation
// - EAh with feature 85h returns state byte
// - bits 7..5 show rw, ro, wp modes
// - bit 4 set while unlocked
// - bit 3 is relock policy flag
// - bit 2 no medium; bits 1:0 zero
// - no security feature: abort state query
// - abort unlock if unsecured or count not 01h
// - unlock when password matches any stored
// - 86h clears, 87h sets relock flag
// - unlocked mismatch aborts, stays unlocked, updates flag
// - seek 70h..7Fh; failure leaves address in registers
// - EFh subcommands; abort unsupported or invalid
// - 01h 8-bit transfers, 81h normal
// - 02h write cache on, 82h off
// - 5Dh/DDh release irq, 5Eh/DEh service irq
// - 66h keeps settings over soft reset; CCh reverts
// - 03h: type upper five, mode lower three
// - 00h default pio, 01h also no iordy
// - 9Ah current = count x 4 mA, clamped to min..max
// - report min and max current in regs 4,5
// - hard reset restores current; soft keeps it
// ************************************************************
module sec_feat_cmd
  import sec_feat_pkg::*;
#(
  parameter bit HAS_SECURITY = 1'b1,
  parameter bit HAS_REMOVABLE = 1'b0,
  parameter bit CAN_DISABLE_IORDY = 1'b1,
  parameter logic [2:0] MAX_PIO_FC = 3'd4,
  parameter logic [2:0] MAX_SW_DMA = 3'd2,
  parameter logic [2:0] MAX_MW_DMA = 3'd2,
  parameter logic [7:0] CUR_MIN = 8'd12,   // 48 mA, in 4 mA steps
  parameter logic [7:0] CUR_MAX = 8'd200,
  parameter logic [7:0] CUR_DEFAULT = 8'd200,
  parameter int NUM_PW = 2,
  parameter int PW_WORDS = 256
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SOFT_RST,
  input wire logic CMD_STROBE,
  input wire logic [7:0] CMD_CODE,
  input wire logic [7:0] FEATURE,
  input wire logic [7:0] SECTOR_COUNT_IN,
  input wire logic [31:0] ADDR_IN,
  input wire logic DATA_VALID,
  input wire logic [15:0] DATA_WORD,
  input wire logic PW_LOAD_EN,
  input wire logic [$clog2(NUM_PW)-1:0] PW_LOAD_IDX,
  input wire logic MODE_RW_IN,
  input wire logic MODE_RO_IN,
  input wire logic MODE_WP_IN,
  input wire logic MEDIUM_PRESENT,
  input wire logic SEEK_DONE,
  input wire logic SEEK_FAIL,
  input wire logic [31:0] SEEK_FAIL_ADDR,
  output logic BUSY,
  output logic DATA_REQ,
  output logic SEEK_START,
  output logic [7:0] ERROR_REG,
  output logic [7:0] SECTOR_COUNT_OUT,
  output logic [31:0] ADDR_OUT,
  output logic [7:0] CUR_LIMIT,
  output logic BUS_8BIT,
  output logic WRITE_CACHE_ON,
  output logic REL_IRQ_ON,
  output logic SVC_IRQ_ON,
  output logic [7:0] XFER_MODE,
  output logic IORDY_OFF,
  output logic UNLOCKED
);
  // ************************************************************
  // state
  // ************************************************************
  typedef enum {S_IDLE, S_DECODE, S_PW, S_SEEK, S_DONE} state_type;
  state_type state_reg;
  logic [7:0] cmd_reg, feat_reg, cnt_reg;
  logic unlocked_reg, lockflag_reg, keep_reg, abort_reg;
  logic bus8_reg, wc_reg, rel_reg, svc_reg, iordy_off_reg;
  logic [7:0] xfer_reg, cur_reg, cnt_out_reg;
  logic [31:0] addr_reg;
  logic pw_start, pw_match_w, pw_done_w, secure_w, xfer_ok;
  logic [7:0] state_byte;

  assign secure_w = MODE_RW_IN | MODE_RO_IN | MODE_WP_IN;

  // state byte assembly
  always_comb begin
    state_byte = 8'h00_00;
    state_byte[BIT_RW] = MODE_RW_IN;
    state_byte[BIT_RO] = MODE_RO_IN;
    state_byte[BIT_WP] = MODE_WP_IN;
    state_byte[BIT_UNLOCKED] = unlocked_reg;
    state_byte[BIT_LOCKFLAG] = lockflag_reg;
    state_byte[BIT_NOMEDIA] = HAS_REMOVABLE && !MEDIUM_PRESENT;
  end

  // transfer mode value check
  always_comb begin
    case (cnt_reg[7:3])
      XT_PIO_DEF: xfer_ok = (cnt_reg[2:0] == 3'h0) ||
                            (cnt_reg[2:0] == MODE_NO_IORDY && CAN_DISABLE_IORDY);
      XT_PIO_FC: xfer_ok = cnt_reg[2:0] <= MAX_PIO_FC;
      XT_SW_DMA: xfer_ok = cnt_reg[2:0] <= MAX_SW_DMA;
      XT_MW_DMA: xfer_ok = cnt_reg[2:0] <= MAX_MW_DMA;
      default: xfer_ok = 1'b0;
    endcase
  end

  pw_match #(.NUM_PW(NUM_PW), .PW_WORDS(PW_WORDS)) pw_match_inst (
    .CLK(CLK),
    .RST(RST),
    .load_en(PW_LOAD_EN),
    .load_idx(PW_LOAD_IDX),
    .start(pw_start),
    .data_valid(DATA_VALID && (state_reg == S_PW || PW_LOAD_EN)),
    .data_word(DATA_WORD),
    .match_reg(pw_match_w),
    .done_reg(pw_done_w)
  );

  assign pw_start = (state_reg == S_DECODE) && cmd_reg == OP_SEC_DO && secure_w &&
                    HAS_SECURITY && cnt_reg == UNLOCK_COUNT &&
                    (feat_reg == SF_UNLOCK_PD || feat_reg == SF_UNLOCK_CMD);

  // ************************************************************
  // command sequencer
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= S_IDLE;
      cmd_reg <= 8'h00_00;
      feat_reg <= 8'h00_00;
      cnt_reg <= 8'h00_00;
      abort_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (CMD_STROBE) begin
            cmd_reg <= CMD_CODE;
            feat_reg <= FEATURE;
            cnt_reg <= SECTOR_COUNT_IN;
            abort_reg <= 1'b0;
            state_reg <= S_DECODE;
          end
        end
        S_DECODE: begin
          state_reg <= S_DONE;
          if (cmd_reg == OP_SEC_ND && feat_reg == SF_STATE) begin
            abort_reg <= !HAS_SECURITY;
          end else if (cmd_reg == OP_SEC_DO &&
                       (feat_reg == SF_UNLOCK_PD || feat_reg == SF_UNLOCK_CMD)) begin
            if (pw_start) state_reg <= S_PW;
            else abort_reg <= 1'b1;
          end else if (cmd_reg >= OP_SEEK_LO && cmd_reg <= OP_SEEK_HI) begin
            state_reg <= S_SEEK;
          end else if (cmd_reg == OP_SETFEAT) begin
            case (feat_reg)
              SC_8BIT_ON, SC_8BIT_OFF, SC_WC_ON, SC_WC_OFF, SC_REL_ON, SC_REL_OFF,
              SC_SVC_ON, SC_SVC_OFF, SC_NOREVERT, SC_REVERT: abort_reg <= 1'b0;
              SC_XFER: abort_reg <= !xfer_ok;
              SC_CURRENT: abort_reg <= (cnt_reg == 8'h00_00);
              default: abort_reg <= 1'b1;
            endcase
          end else begin
            abort_reg <= 1'b1;
          end
        end
        S_PW: begin
          if (pw_done_w) begin
            abort_reg <= !pw_match_w;
            state_reg <= S_DONE;
          end
        end
        S_SEEK: begin
          if (SEEK_DONE) begin
            abort_reg <= SEEK_FAIL;
            state_reg <= S_DONE;
          end
        end
        S_DONE: state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ************************************************************
  // security state
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      unlocked_reg <= 1'b0;
      lockflag_reg <= 1'b0;
    end else if (!secure_w) begin
      unlocked_reg <= 1'b0;
      lockflag_reg <= 1'b0;
    end else if (state_reg == S_PW && pw_done_w) begin
      if (pw_match_w) unlocked_reg <= 1'b1;
      if (pw_match_w || unlocked_reg) begin
        lockflag_reg <= (feat_reg == SF_UNLOCK_CMD);
      end
    end
  end

  // ************************************************************
  // feature settings
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      bus8_reg <= 1'b0;
      wc_reg <= 1'b0;
      rel_reg <= 1'b0;
      svc_reg <= 1'b0;
      keep_reg <= 1'b0;
      xfer_reg <= MODE_RESET;
      iordy_off_reg <= 1'b0;
      cur_reg <= CUR_DEFAULT;
    end else if (SOFT_RST && !keep_reg) begin
      bus8_reg <= 1'b0;
      wc_reg <= 1'b0;
      rel_reg <= 1'b0;
      svc_reg <= 1'b0;
    end else if (state_reg == S_DECODE && cmd_reg == OP_SETFEAT) begin
      case (feat_reg)
        SC_8BIT_ON: bus8_reg <= 1'b1;
        SC_8BIT_OFF: bus8_reg <= 1'b0;
        SC_WC_ON: wc_reg <= 1'b1;
        SC_WC_OFF: wc_reg <= 1'b0;
        SC_REL_ON: rel_reg <= 1'b1;
        SC_REL_OFF: rel_reg <= 1'b0;
        SC_SVC_ON: svc_reg <= 1'b1;
        SC_SVC_OFF: svc_reg <= 1'b0;
        SC_NOREVERT: keep_reg <= 1'b1;
        SC_REVERT: keep_reg <= 1'b0;
        SC_XFER: begin
          if (xfer_ok) begin
            xfer_reg <= cnt_reg;
            iordy_off_reg <= (cnt_reg[7:3] == XT_PIO_DEF) && cnt_reg[0];
          end
        end
        SC_CURRENT: begin
          if (cnt_reg != 8'h00_00) begin
            cur_reg <= (cnt_reg < CUR_MIN) ? CUR_MIN :
                       (cnt_reg > CUR_MAX) ? CUR_MAX : cnt_reg;
          end
        end
        default: ;
      endcase
    end
  end

  // ************************************************************
  // result registers
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_out_reg <= 8'h00_00;
      addr_reg <= 32'h0000_0000;
    end else if (state_reg == S_IDLE && CMD_STROBE) begin
      cnt_out_reg <= SECTOR_COUNT_IN;
      addr_reg <= ADDR_IN;
    end else if (state_reg == S_DECODE) begin
      if (cmd_reg == OP_SEC_ND && feat_reg == SF_STATE && HAS_SECURITY) begin
        cnt_out_reg <= state_byte;
      end
      if (cmd_reg == OP_SETFEAT && feat_reg == SC_CURRENT && cnt_reg != 8'h00_00) begin
        addr_reg[15:8] <= CUR_MIN;
        addr_reg[23:16] <= CUR_MAX;
      end
    end else if (state_reg == S_SEEK && SEEK_DONE && SEEK_FAIL) begin
      addr_reg <= SEEK_FAIL_ADDR;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign BUSY = (state_reg != S_IDLE);
  assign DATA_REQ = (state_reg == S_PW);
  assign SEEK_START = (state_reg == S_DECODE) && cmd_reg >= OP_SEEK_LO && cmd_reg <= OP_SEEK_HI;
  assign ERROR_REG = abort_reg ? ERR_ABORT : 8'h00_00;
  assign SECTOR_COUNT_OUT = cnt_out_reg;
  assign ADDR_OUT = addr_reg;
  assign CUR_LIMIT = cur_reg;
  assign BUS_8BIT = bus8_reg;
  assign WRITE_CACHE_ON = wc_reg;
  assign REL_IRQ_ON = rel_reg;
  assign SVC_IRQ_ON = svc_reg;
  assign XFER_MODE = xfer_reg;
  assign IORDY_OFF = iordy_off_reg;
  assign UNLOCKED = unlocked_reg;

  // ************************************************************
  // checks
  // ************************************************************
  a_state_query_byte: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == S_DECODE && cmd_reg == OP_SEC_ND && feat_reg == SF_STATE && HAS_SECURITY)
    |=> SECTOR_COUNT_OUT[1:0] == 2'b00 && SECTOR_COUNT_OUT[BIT_UNLOCKED] == $past(unlocked_reg))
    else $error("state byte wrong");
  a_unlock_bad_count: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == S_DECODE && cmd_reg == OP_SEC_DO &&
     (feat_reg == SF_UNLOCK_PD || feat_reg == SF_UNLOCK_CMD) &&
     cnt_reg != UNLOCK_COUNT) |=> abort_reg && state_reg == S_DONE)
    else $error("bad unlock count not aborted");
  a_unlock_stays: assert property (@(posedge CLK) disable iff (RST)
    (unlocked_reg && secure_w && state_reg == S_PW && pw_done_w) |=> unlocked_reg)
    else $error("unlock verify relocked");
  a_flag_policy: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == S_PW && pw_done_w && pw_match_w && secure_w)
    |=> lockflag_reg == ($past(feat_reg) == SF_UNLOCK_CMD))
    else $error("lock flag policy wrong");
  a_current_range: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == S_DONE && $past(cmd_reg) == OP_SETFEAT && feat_reg == SC_CURRENT && !abort_reg)
    |-> CUR_LIMIT >= CUR_MIN && CUR_LIMIT <= cnt_reg || CUR_LIMIT == CUR_MIN)
    else $error("current limit out of range");
  a_current_zero: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == S_DECODE && cmd_reg == OP_SETFEAT && feat_reg == SC_CURRENT &&
     cnt_reg == 8'h00_00) |=> abort_reg ##0 $stable(cur_reg))
    else $error("zero current not aborted");
  a_soft_keeps_cur: assert property (@(posedge CLK) disable iff (RST)
    (SOFT_RST && state_reg == S_IDLE) |=> $stable(cur_reg))
    else $error("soft reset changed current");
  a_busy_result: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == S_IDLE && CMD_STROBE) |=> BUSY [*2])
    else $error("busy not held");
  a_seek_fail_addr: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == S_SEEK && SEEK_DONE && SEEK_FAIL) |=> ADDR_OUT == $past(SEEK_FAIL_ADDR) && abort_reg)
    else $error("seek failure address lost");
endmodule : sec_feat_cmd

// ---- tb/host_model.sv ----
`timescale 1ns/100ps
// host side model that streams password words into the block
module host_model #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic req,
  input wire logic load,
  input wire logic slow,
  input wire logic [63:0] pw,
  output logic valid,
  output logic [15:0] word
);
  int cnt = 0;
  logic gap = 1'b0;
  initial begin
    valid = 1'b0;
    word = 16'h0000;
  end
  // one password, first word first; an idle bus shows the inverse of its last value
  always @(negedge clk) begin
    if (valid) begin
      cnt = cnt + 1;
    end
    valid = 1'b0;
    word = ~word;
    if ((req || load) && cnt < N && !(slow && gap)) begin
      valid = 1'b1;
      word = pw[16*cnt +: 16];
    end
    if (!req && !load) begin
      cnt = 0;
    end
    gap = ~gap;
  end
endmodule : host_model

// ---- tb/tb.sv ----
`timescale 1ns/100ps
// self-checking testbench for the security and feature command block
module tb;
  import sec_feat_pkg::*;
  localparam logic [7:0] CMIN = 8'd12, CMAX = 8'd200, CDEF = 8'd200;
  localparam logic [63:0] PW_A = 64'h1111_2222_3333_4444, PW_B = 64'hA5A5_0F0F_C3C3_7E7E;
  logic clk = 1'b0, rst = 1'b1, soft_rst = 1'b0, cmd_strobe = 1'b0, data_valid, pw_load_en = 1'b0;
  logic [7:0] cmd_code = 8'h00, feature = 8'h00, sector_count_in = 8'h00;
  logic [31:0] addr_in = 32'h0000_0000, seek_fail_addr = 32'h0000_0000;
  logic [15:0] data_word;
  logic pw_load_idx = 1'b0, mode_rw = 1'b0, mode_ro = 1'b0, mode_wp = 1'b0;
  logic medium_present = 1'b1, seek_done = 1'b0, seek_fail = 1'b0, load_req = 1'b0, slow = 1'b0;
  logic busy, data_req, seek_start, bus_8bit, write_cache_on, rel_irq_on, svc_irq_on, iordy_off;
  logic unlocked;
  logic [7:0] error_reg, sector_count_out, cur_limit, xfer_mode;
  logic [31:0] addr_out;
  logic [63:0] host_pw = PW_A;
  logic [3:0] flags;
  int err_count = 0, comparisons = 0, busy_n = 0, starts = 0, wait_n = 0;
  always #20 clk = ~clk;
  assign flags = {bus_8bit, write_cache_on, rel_irq_on, svc_irq_on};
  sec_feat_cmd #(.CUR_MIN(CMIN), .CUR_MAX(CMAX), .CUR_DEFAULT(CDEF), .PW_WORDS(4)) sec_feat_cmd_inst (
    .CLK(clk), .RST(rst), .SOFT_RST(soft_rst), .CMD_STROBE(cmd_strobe), .CMD_CODE(cmd_code),
    .FEATURE(feature), .SECTOR_COUNT_IN(sector_count_in), .ADDR_IN(addr_in),
    .DATA_VALID(data_valid), .DATA_WORD(data_word), .PW_LOAD_EN(pw_load_en),
    .PW_LOAD_IDX(pw_load_idx), .MODE_RW_IN(mode_rw), .MODE_RO_IN(mode_ro), .MODE_WP_IN(mode_wp),
    .MEDIUM_PRESENT(medium_present), .SEEK_DONE(seek_done), .SEEK_FAIL(seek_fail),
    .SEEK_FAIL_ADDR(seek_fail_addr), .BUSY(busy), .DATA_REQ(data_req), .SEEK_START(seek_start),
    .ERROR_REG(error_reg), .SECTOR_COUNT_OUT(sector_count_out), .ADDR_OUT(addr_out),
    .CUR_LIMIT(cur_limit), .BUS_8BIT(bus_8bit), .WRITE_CACHE_ON(write_cache_on),
    .REL_IRQ_ON(rel_irq_on), .SVC_IRQ_ON(svc_irq_on), .XFER_MODE(xfer_mode),
    .IORDY_OFF(iordy_off), .UNLOCKED(unlocked));
  host_model #(.N(4)) host_model_inst (.clk(clk), .req(data_req), .load(load_req), .slow(slow),
    .pw(host_pw), .valid(data_valid), .word(data_word));
  // positioning stand-in: ends a seek three cycles after it starts
  always @(negedge clk) begin
    if (seek_start === 1'b1) begin
      starts <= starts + 1;
      wait_n <= 3;
    end else if (wait_n != 0) begin
      wait_n <= wait_n - 1;
    end
    seek_done <= (wait_n == 1) && (seek_start !== 1'b1);
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // issue one command at a falling edge and wait, bounded, until busy drops
  task automatic cmd(input logic [7:0] op, input logic [7:0] ft, input logic [7:0] sc,
                     input logic [31:0] ad);
    cmd_code = op;
    feature = ft;
    sector_count_in = sc;
    addr_in = ad;
    cmd_strobe = 1'b1;
    @(negedge clk);
    cmd_strobe = 1'b0;
    busy_n = 0;
    while (busy === 1'b1 && busy_n < 3000) begin
      busy_n++;
      @(negedge clk);
    end
    if (busy_n >= 3000) begin
      err_count++;
      wrap_up();
    end
  endtask : cmd
  task automatic load_pw(input logic idx, input logic [63:0] pw);
    pw_load_en = 1'b1;
    pw_load_idx = idx;
    host_pw = pw;
    load_req = 1'b1;
    repeat (8) @(negedge clk);
    load_req = 1'b0;
    pw_load_en = 1'b0;
    // two idle edges so the host model surely sees the load end
    @(negedge clk);
    @(negedge clk);
  endtask : load_pw
  task automatic pulse(input bit hard);
    if (hard) rst = 1'b1;
    else soft_rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    soft_rst = 1'b0;
    @(negedge clk);
  endtask : pulse
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    chk(busy, 1'b0);
    chk(error_reg, 8'h00);
    chk(cur_limit, CDEF);
    chk(unlocked, 1'b0);
    chk(data_req, 1'b0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_state();
    for (int i = 0; i < 8; i++) begin
      {mode_rw, mode_ro, mode_wp} = i[2:0];
      medium_present = i[0];
      cmd(OP_SEC_ND, SF_STATE, 8'h00, 32'h0000_0000);
      chk(sector_count_out, {i[2:0], 5'b00000});
      chk(busy_n, 2);
    end
    $display("test state done");
  endtask : t_state
  task automatic t_unlock();
    {mode_rw, mode_ro, mode_wp} = 3'b000;
    load_pw(1'b0, PW_A);
    load_pw(1'b1, PW_B);
    host_pw = PW_A;
    cmd(OP_SEC_DO, SF_UNLOCK_CMD, UNLOCK_COUNT, 32'h0000_0000);
    chk(error_reg, ERR_ABORT);
    mode_ro = 1'b1;
    cmd(OP_SEC_DO, SF_UNLOCK_CMD, 8'h02, 32'h0000_0000);
    chk(error_reg, ERR_ABORT);
    host_pw = 64'h0BAD_0BAD_0BAD_0BAD;
    cmd(OP_SEC_DO, SF_UNLOCK_CMD, UNLOCK_COUNT, 32'h0000_0000);
    chk({error_reg, unlocked}, {ERR_ABORT, 1'b0});
    host_pw = PW_B;
    slow = 1'b1;
    cmd(OP_SEC_DO, SF_UNLOCK_CMD, UNLOCK_COUNT, 32'h0000_0000);
    chk({error_reg, unlocked}, {8'h00, 1'b1});
    slow = 1'b0;
    cmd(OP_SEC_ND, SF_STATE, 8'h00, 32'h0000_0000);
    chk(sector_count_out, 8'h58);
    // only the final word differs from a stored password
    host_pw = {16'h0BAD, PW_A[47:0]};
    cmd(OP_SEC_DO, SF_UNLOCK_PD, UNLOCK_COUNT, 32'h0000_0000);
    chk({error_reg, unlocked}, {ERR_ABORT, 1'b1});
    cmd(OP_SEC_ND, SF_STATE, 8'h00, 32'h0000_0000);
    chk(sector_count_out, 8'h50);
    $display("test unlock done");
  endtask : t_unlock
  task automatic t_seek();
    cmd(OP_SEEK_LO, 8'h00, 8'h00, 32'h0012_3456);
    chk({error_reg, 8'(starts)}, {8'h00, 8'h01});
    seek_fail = 1'b1;
    seek_fail_addr = 32'h00AB_CDEF;
    cmd(OP_SEEK_HI, 8'h00, 8'h00, 32'h0000_1111);
    chk(addr_out, 32'h00AB_CDEF);
    seek_fail = 1'b0;
    cmd(8'hC6, 8'h00, 8'h00, 32'h0000_0000);
    chk({error_reg, 8'(starts)}, {ERR_ABORT, 8'h02});
    $display("test seek done");
  endtask : t_seek
  task automatic t_feat();
    logic [7:0] on_c [4] = '{SC_8BIT_ON, SC_WC_ON, SC_REL_ON, SC_SVC_ON};
    logic [7:0] off_c [4] = '{SC_8BIT_OFF, SC_WC_OFF, SC_REL_OFF, SC_SVC_OFF};
    for (int k = 0; k < 4; k++) begin
      cmd(OP_SETFEAT, on_c[k], 8'h00, 32'h0000_0000);
      chk(flags, 4'b1000 >> k);
      cmd(OP_SETFEAT, off_c[k], 8'h00, 32'h0000_0000);
      chk(flags, 4'b0000);
    end
    cmd(OP_SETFEAT, 8'h33, 8'h00, 32'h0000_0000);
    chk(error_reg, ERR_ABORT);
    $display("test features done");
  endtask : t_feat
  task automatic t_xfer();
    logic [7:0] val [7] = '{8'h00, 8'h01, 8'h0C, 8'h12, 8'h22, 8'h23, 8'h40};
    logic [7:0] mode [7] = '{8'h00, 8'h01, 8'h0C, 8'h12, 8'h22, 8'h22, 8'h22};
    for (int k = 0; k < 7; k++) begin
      cmd(OP_SETFEAT, SC_XFER, val[k], 32'h0000_0000);
      chk({error_reg, xfer_mode}, {(k > 4) ? ERR_ABORT : 8'h00, mode[k]});
      if (k < 2) chk(iordy_off, k[0]);
    end
    $display("test transfer mode done");
  endtask : t_xfer
  task automatic t_revert();
    cmd(OP_SETFEAT, SC_8BIT_ON, 8'h00, 32'h0000_0000);
    pulse(1'b0);
    chk(bus_8bit, 1'b0);
    cmd(OP_SETFEAT, SC_NOREVERT, 8'h00, 32'h0000_0000);
    cmd(OP_SETFEAT, SC_8BIT_ON, 8'h00, 32'h0000_0000);
    pulse(1'b0);
    chk(bus_8bit, 1'b1);
    cmd(OP_SETFEAT, SC_REVERT, 8'h00, 32'h0000_0000);
    pulse(1'b0);
    chk(bus_8bit, 1'b0);
    $display("test revert done");
  endtask : t_revert
  task automatic t_current();
    logic [7:0] req [4] = '{8'd5, 8'd255, 8'd0, 8'd32};
    logic [7:0] lim [4] = '{CMIN, CMAX, CMAX, 8'd32};
    for (int k = 0; k < 4; k++) begin
      cmd(OP_SETFEAT, SC_CURRENT, req[k], 32'h0000_0000);
      chk({error_reg, cur_limit}, {(k == 2) ? ERR_ABORT : 8'h00, lim[k]});
      if (k != 2) chk(addr_out[23:8], {CMAX, CMIN});
    end
    pulse(1'b0);
    chk(cur_limit, 8'd32);
    pulse(1'b1);
    chk(cur_limit, CDEF);
    $display("test current done");
  endtask : t_current
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_state();
    t_unlock();
    t_seek();
    t_feat();
    t_xfer();
    t_revert();
    t_current();
    wrap_up();
  end
endmodule : tb
